// ==== mccr_pkg.sv ====
/*
  Constants for the master control and configuration register pair:
  register offsets, bit positions, reset values and bandgap encodings.
  Assumes an 8-bit register port with 8-bit addresses.
*/
package mccr_pkg;
  localparam logic [7:0] MCCR_ADDR_CONTROL = 8'hA0;
  localparam logic [7:0] MCCR_ADDR_CONFIG = 8'hA1;
  localparam logic [7:0] MCCR_RESET_VALUE = 8'h00;
  localparam int MCCR_BIT_LF_BYPASS = 7;
  localparam int MCCR_BIT_STATUS_CLEAR = 6;
  localparam int MCCR_BIT_ADDR_INVERT = 5;
  localparam int MCCR_BIT_OSC_DISABLE = 4;
  localparam int MCCR_BIT_SRAM_DISABLE = 3;
  localparam int MCCR_BIT_CLK_OVERRIDE = 2;
  localparam int MCCR_BIT_MEM_RESET = 1;
  localparam int MCCR_BIT_LCD_ENABLE = 0;
  localparam int MCCR_BIT_BG_HI = 7;
  localparam int MCCR_BIT_BG_LO = 6;
  localparam int MCCR_BIT_CP_BYPASS = 0;
  localparam logic [7:0] MCCR_CONFIG_WMASK = 8'hC1;
  localparam logic [7:0] MCCR_CONTROL_WMASK = 8'hBD;
  localparam logic [2:0] MCCR_WAKE_NONE = 3'h0;
  localparam int MCCR_WAKE_OSC_FAIL = 2;
  localparam int MCCR_WAKE_ALARM = 1;
  localparam int MCCR_WAKE_PORTMATCH = 0;
  localparam int MCCR_MEM_DEPTH = 16;
  localparam logic [7:0] MCCR_MEM_CLEAR = 8'h00;

  typedef enum logic [1:0] {
    MCCR_BG_NORMAL = 2'b00,
    MCCR_BG_RESERVED = 2'b01,
    MCCR_BG_LOW_LOOSE = 2'b10,
    MCCR_BG_LOW_TIGHT = 2'b11
  } mccr_bg_mode_t;
endpackage : mccr_pkg

// ==== mccr_lowpower_mem.sv ====
/*
  Low-power memory kept beside the control registers: sixteen bytes that
  hold port-match masks and display data, with a one-cycle bulk clear.
  Assumes one synchronous write port and a registered read port.
*/
`timescale 1ns/1ns
module mccr_lowpower_mem
  import mccr_pkg::*;
#(
  parameter int DEPTH = MCCR_MEM_DEPTH,
  parameter int AW = $clog2(DEPTH)
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Access port
  input wire logic wrEn,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  // Bulk clear
  input wire logic clearAll
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] mem_d [DEPTH];
  logic [7:0] rdData_d;

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_d[i] = mem_q[i];
    end
    if (clearAll)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_d[i] = MCCR_MEM_CLEAR;
      end
    end
    else if (wrEn)
    begin
      mem_d[addr] = wrData;
    end
    rdData_d = mem_q[addr];
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= MCCR_MEM_CLEAR;
      end
      rdData <= MCCR_MEM_CLEAR;
    end
    else
    begin
      mem_q <= mem_d;
      rdData <= rdData_d;
    end
  end
endmodule : mccr_lowpower_mem

// ==== mccr_master_regs.sv ====
/*
  Master control and master configuration registers, with the wake-up
  source status flags they clear and the low-power memory they reset.
  Assumes a simple synchronous 8-bit register port driven by the serial
  host port decoder, and wake events as one-cycle pulses.
*/
`timescale 1ns/1ns
module mccr_master_regs
  import mccr_pkg::*;
#(
  parameter int SRAM_AW = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port from the serial host decoder
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Low-power memory port from the host decoder
  input wire logic memWrite,
  input wire logic [3:0] memAddr,
  input wire logic [7:0] memWrData,
  output logic [7:0] memRdData,
  // Wake-up source events
  input wire logic oscFailEvent,
  input wire logic alarmEvent,
  input wire logic portmatchEvent,
  output logic [2:0] wakeupSourceStatus,
  // Clock steering
  input wire logic lfOscClk,
  input wire logic extClkPin,
  input wire logic [1:0] clockSelect,
  output logic lfClkFromPin,
  output logic lfOscGate,
  output logic sysclkFromPin,
  output logic [1:0] sysclkSource,
  // SRAM address path
  input wire logic [SRAM_AW-1:0] sramAddrIn,
  output logic [SRAM_AW-1:0] sramAddrOut,
  output logic sramEnable,
  // Analog and display controls
  output logic lcdEnable,
  output logic [1:0] bandgapMode,
  output logic chargePumpEnable,
  output logic lcdSupplyFromMain
);
  logic [7:0] control_q, control_d;
  logic [7:0] config_q, config_d;
  logic [2:0] status_q, status_d;
  logic [7:0] rd_d;
  logic [SRAM_AW-1:0] sramAddr_d;
  logic ctlWr, cfgWr, statusClear, memClear;
  logic lfClkFromPin_d, lfOscGate_d, sysclkFromPin_d, sramEnable_d;
  logic lcdEnable_d, chargePumpEnable_d, lcdSupplyFromMain_d;
  logic [1:0] sysclkSource_d, bandgapMode_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign ctlWr = regWrite && hit(regAddr, MCCR_ADDR_CONTROL);
  assign cfgWr = regWrite && hit(regAddr, MCCR_ADDR_CONFIG);
  // Strobes fire only on a written one; a written zero does nothing.
  assign statusClear = ctlWr && regWrData[MCCR_BIT_STATUS_CLEAR];
  assign memClear = ctlWr && regWrData[MCCR_BIT_MEM_RESET];

  mccr_lowpower_mem u_mem (
    .clk(clk),
    .reset_n(reset_n),
    .wrEn(memWrite),
    .addr(memAddr),
    .wrData(memWrData),
    .rdData(memRdData),
    .clearAll(memClear)
  );

  always_comb
  begin
    control_d = control_q;
    config_d = config_q;
    status_d = status_q;
    if (ctlWr)
    begin
      // Strobe bits are never stored, so they read back as zero.
      control_d = regWrData & MCCR_CONTROL_WMASK;
    end
    if (cfgWr)
    begin
      // Reserved bits are not stored and read as zero.
      config_d = regWrData & MCCR_CONFIG_WMASK;
    end
    if (statusClear)
    begin
      status_d = MCCR_WAKE_NONE;
    end
    // An event in the clearing cycle must survive, so set wins.
    status_d[MCCR_WAKE_OSC_FAIL] = status_d[MCCR_WAKE_OSC_FAIL]
      | oscFailEvent;
    status_d[MCCR_WAKE_ALARM] = status_d[MCCR_WAKE_ALARM] | alarmEvent;
    status_d[MCCR_WAKE_PORTMATCH] = status_d[MCCR_WAKE_PORTMATCH]
      | portmatchEvent;
    rd_d = regRdData;
    if (regRead)
    begin
      if (hit(regAddr, MCCR_ADDR_CONTROL))
      begin
        rd_d = control_q;
      end
      else if (hit(regAddr, MCCR_ADDR_CONFIG))
      begin
        rd_d = config_q;
      end
      else
      begin
        rd_d = 8'h00;
      end
    end
    sramAddr_d = sramAddrIn;
    if (control_q[MCCR_BIT_ADDR_INVERT])
    begin
      sramAddr_d[7:0] = ~sramAddrIn[7:0];
    end
    lfClkFromPin_d = control_q[MCCR_BIT_LF_BYPASS];
    // The oscillator is gated off whenever it is disabled or bypassed.
    lfOscGate_d = ~control_q[MCCR_BIT_OSC_DISABLE]
      & ~control_q[MCCR_BIT_LF_BYPASS];
    sysclkFromPin_d = control_q[MCCR_BIT_CLK_OVERRIDE];
    sysclkSource_d = control_q[MCCR_BIT_CLK_OVERRIDE] ? 2'h0
      : clockSelect;
    sramEnable_d = ~control_q[MCCR_BIT_SRAM_DISABLE];
    lcdEnable_d = control_q[MCCR_BIT_LCD_ENABLE];
    bandgapMode_d = config_q[MCCR_BIT_BG_HI:MCCR_BIT_BG_LO];
    chargePumpEnable_d = ~config_q[MCCR_BIT_CP_BYPASS];
    lcdSupplyFromMain_d = config_q[MCCR_BIT_CP_BYPASS];
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      control_q <= MCCR_RESET_VALUE;
      config_q <= MCCR_RESET_VALUE;
      status_q <= MCCR_WAKE_NONE;
      regRdData <= 8'h00;
      sramAddrOut <= '0;
      wakeupSourceStatus <= MCCR_WAKE_NONE;
      lfClkFromPin <= 1'b0;
      lfOscGate <= 1'b1;
      sysclkFromPin <= 1'b0;
      sysclkSource <= 2'h0;
      sramEnable <= 1'b1;
      lcdEnable <= 1'b0;
      bandgapMode <= MCCR_BG_NORMAL;
      chargePumpEnable <= 1'b1;
      lcdSupplyFromMain <= 1'b0;
    end
    else
    begin
      control_q <= control_d;
      config_q <= config_d;
      status_q <= status_d;
      regRdData <= rd_d;
      sramAddrOut <= sramAddr_d;
      wakeupSourceStatus <= status_q;
      lfClkFromPin <= lfClkFromPin_d;
      lfOscGate <= lfOscGate_d;
      sysclkFromPin <= sysclkFromPin_d;
      sysclkSource <= sysclkSource_d;
      sramEnable <= sramEnable_d;
      lcdEnable <= lcdEnable_d;
      bandgapMode <= bandgapMode_d;
      chargePumpEnable <= chargePumpEnable_d;
      lcdSupplyFromMain <= lcdSupplyFromMain_d;
    end
  end

  AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    statusClear && !oscFailEvent && !alarmEvent && !portmatchEvent
    |=> status_q == MCCR_WAKE_NONE ##1 wakeupSourceStatus == MCCR_WAKE_NONE)
    else $error("status not cleared");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n)
    alarmEvent |=> status_q[MCCR_WAKE_ALARM])
    else $error("alarm event lost");
  AST_STROBE_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
    control_q[MCCR_BIT_STATUS_CLEAR] == 1'b0
    && control_q[MCCR_BIT_MEM_RESET] == 1'b0)
    else $error("strobe bit stored");
  AST_ADDR_INVERT: assert property (@(posedge clk) disable iff (!reset_n)
    control_q[MCCR_BIT_ADDR_INVERT]
    |=> sramAddrOut[7:0] == ~$past(sramAddrIn[7:0]))
    else $error("address not inverted");
  AST_SRAM_EN: assert property (@(posedge clk) disable iff (!reset_n)
    ctlWr |=> ##1 sramEnable == !$past(regWrData[MCCR_BIT_SRAM_DISABLE], 2))
    else $error("sram enable wrong");
  AST_MEM_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    memClear |=> ##1 memRdData == MCCR_MEM_CLEAR)
    else $error("memory not cleared");
  AST_LCD_EN: assert property (@(posedge clk) disable iff (!reset_n)
    ctlWr |=> ##1 lcdEnable == $past(regWrData[MCCR_BIT_LCD_ENABLE], 2))
    else $error("lcd enable wrong");
  AST_CFG_RESERVED: assert property (@(posedge clk) disable iff (!reset_n)
    cfgWr |=> config_q[5:1] == 5'h00
    ##1 bandgapMode == $past(regWrData[7:6], 2))
    else $error("config write wrong");
  AST_OSC_GATE: assert property (@(posedge clk) disable iff (!reset_n)
    control_q[MCCR_BIT_OSC_DISABLE] |=> !lfOscGate)
    else $error("oscillator not gated");
  AST_CLK_OVR: assert property (@(posedge clk) disable iff (!reset_n)
    control_q[MCCR_BIT_CLK_OVERRIDE] |=> sysclkFromPin && sysclkSource == 2'h0)
    else $error("override ignored");
  AST_CP_BYP: assert property (@(posedge clk) disable iff (!reset_n)
    config_q[MCCR_BIT_CP_BYPASS] |=> !chargePumpEnable && lcdSupplyFromMain)
    else $error("pump not bypassed");
  AST_LF_BYP: assert property (@(posedge clk) disable iff (!reset_n)
    control_q[MCCR_BIT_LF_BYPASS] |=> lfClkFromPin)
    else $error("bypass ignored");
endmodule : mccr_master_regs

// ==== mccr_host_model.sv ====
/*
  Host-side model of the serial register port: single-byte transfers.
  Assumes its caller runs between falling edges of the system clock.
*/
`timescale 1ns/1ns
module mccr_host_model
  import mccr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'hFF;
    regWrData = 8'h00;
  end

  // Before shutdown the host loads the loose low-power bandgap code, and in
  // that mode it paces the display so pump cycles stay 2 ms apart; the pacing
  // lives in display settings outside this port.
  // Released lines carry the inverse, so a stale value never looks valid.
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    regWrite = wr;
    regRead = ~wr;
    regAddr = a;
    regWrData = d;
    if (a == MCCR_ADDR_CONFIG)
      regWrData = d & MCCR_CONFIG_WMASK;
    @(negedge clk);
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = ~a;
    regWrData = ~regWrData;
    @(negedge clk);
    q = regRdData;
  endtask : xfer
endmodule : mccr_host_model

// ==== test_master_control_config_regs.sv ====
/*
  Self-checking bench for the master register pair: reset checks, then a
  table of writes and readbacks, then wake flag and memory clear cases.
  Assumes a 100 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/1ns
module test_master_control_config_regs
  import mccr_pkg::*;
;
  typedef struct packed
  {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] rd;
  } mccr_row_t;
  logic clk = 1'b0;
  logic reset_n, regWrite, regRead, memWrite;
  logic [7:0] regAddr, regWrData, regRdData, memWrData, memRdData;
  logic [7:0] q, ctl, cfg;
  logic [3:0] memAddr;
  logic [2:0] ev, wakeStat, w;
  logic [1:0] clkSel, sysSrc, bgMode;
  logic lfPin, oscGate, sysPin, sramEn, lcd_enable, cpEn, lcdMain;
  logic [15:0] sramIn, sramOut;
  int err_total = 0;
  int check_count = 0;
  // The 0xA1/0x80 row is the loose low-power code set before shutdown.
  mccr_row_t rows [14] = '{'{8'hA0, 8'hFF, 8'hBD}, '{8'hA0, 8'h90, 8'h90},
    '{8'hA0, 8'h10, 8'h10}, '{8'hA0, 8'h04, 8'h04}, '{8'hA0, 8'h08, 8'h08},
    '{8'hA0, 8'h20, 8'h20}, '{8'hA0, 8'h01, 8'h01}, '{8'hA1, 8'h40, 8'h40},
    '{8'hA1, 8'h80, 8'h80}, '{8'hA1, 8'hC0, 8'hC0}, '{8'hA1, 8'h3F, 8'h01},
    '{8'hA2, 8'hFF, 8'h00}, '{8'hA1, 8'h00, 8'h00}, '{8'hA0, 8'h00, 8'h00}};

  always #5 clk = ~clk;

  mccr_host_model mccr_host_model_i (.clk(clk), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData));

  mccr_master_regs mccr_master_regs_i (.clk(clk), .reset_n(reset_n),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .memWrite(memWrite),
    .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
    .oscFailEvent(ev[2]), .alarmEvent(ev[1]), .portmatchEvent(ev[0]),
    .wakeupSourceStatus(wakeStat), .lfOscClk(1'b0), .extClkPin(1'b0),
    .clockSelect(clkSel), .lfClkFromPin(lfPin), .lfOscGate(oscGate),
    .sysclkFromPin(sysPin), .sysclkSource(sysSrc), .sramAddrIn(sramIn),
    .sramAddrOut(sramOut), .sramEnable(sramEn), .lcdEnable(lcd_enable),
    .bandgapMode(bgMode), .chargePumpEnable(cpEn),
    .lcdSupplyFromMain(lcdMain));

  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (e !== g)
    begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  task automatic chk_out();
    logic [15:0] a;
    a = ctl[5] ? {sramIn[15:8], ~sramIn[7:0]} : sramIn;
    chk("sramAddrOut", a, sramOut);
    chk("clocks", {ctl[7], ~(ctl[4] | ctl[7]), ctl[2],
      ctl[2] ? 2'h0 : clkSel}, {lfPin, oscGate, sysPin, sysSrc});
    chk("lcd", {~ctl[3], ctl[0], cfg[7:6], ~cfg[0], cfg[0]},
      {sramEn, lcd_enable, bgMode, cpEn, lcdMain});
  endtask : chk_out

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // Every wait below is a fixed count, so this only guards a stuck run.
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial
  begin
    {reset_n, memWrite, memAddr, memWrData, ev, ctl, cfg} = '0;
    clkSel = 2'h2;
    sramIn = 16'h0412;
    repeat (6) @(negedge clk);
    // Reset clears the output registers too, so the address is not passed.
    chk("reset sram", 16'h0000, sramOut);
    chk("reset outs",
      {1'b0, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0},
      {lfPin, oscGate, sysPin, sysSrc, sramEn, lcd_enable, bgMode, cpEn, lcdMain});
    chk("reset reads", 19'h0, {regRdData, memRdData, wakeStat});
    reset_n = 1'b1;
    mccr_host_model_i.xfer(1'b0, MCCR_ADDR_CONFIG, 8'h00, q);
    chk("reset config", 8'h00, q);
    for (int i = 0; i < 14; i++)
    begin
      mccr_host_model_i.xfer(1'b1, rows[i].a, rows[i].d, q);
      if (rows[i].a == MCCR_ADDR_CONTROL)
        ctl = rows[i].d & MCCR_CONTROL_WMASK;
      if (rows[i].a == MCCR_ADDR_CONFIG)
        cfg = rows[i].d & MCCR_CONFIG_WMASK;
      mccr_host_model_i.xfer(1'b0, rows[i].a, 8'h00, q);
      chk("readback", rows[i].rd, q);
      chk_out();
    end
    for (int k = 2; k >= 0; k--)
    begin
      @(negedge clk);
      ev[k] = 1'b1;
      @(negedge clk);
      ev[k] = 1'b0;
      repeat (2) @(negedge clk);
      w = 3'h7 << k;
      chk("wake flags", w, wakeStat);
    end
    mccr_host_model_i.xfer(1'b1, MCCR_ADDR_CONTROL, 8'h00, q);
    repeat (2) @(negedge clk);
    chk("flags kept", 3'h7, wakeStat);
    mccr_host_model_i.xfer(1'b1, MCCR_ADDR_CONTROL, 8'h40, q);
    repeat (2) @(negedge clk);
    chk("flags cleared", MCCR_WAKE_NONE, wakeStat);
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk);
      memWrite = 1'b1;
      memAddr = k ? 4'hF : 4'h3;
      memWrData = k ? 8'h3C : 8'hA5;
      @(negedge clk);
      memWrite = 1'b0;
      repeat (2) @(negedge clk);
      chk("memory", k ? 8'h3C : 8'hA5, memRdData);
    end
    mccr_host_model_i.xfer(1'b1, MCCR_ADDR_CONTROL, 8'h02, q);
    mccr_host_model_i.xfer(1'b0, MCCR_ADDR_CONTROL, 8'h00, q);
    chk("strobe readback", 8'h00, q);
    for (int k = 0; k < 2; k++)
    begin
      memAddr = k ? 4'h3 : 4'hF;
      repeat (2) @(negedge clk);
      chk("memory cleared", MCCR_MEM_CLEAR, memRdData);
    end
    finish_test();
  end
endmodule : test_master_control_config_regs
